// ==== common/swc_pkg.sv ====
// swc_pkg: shared constants and types for the sleep and wake-up controller
// assumes one 50 MHz system clock and a slow-clock tick delivered as an enable pulse
// Operation
// - hibernation stops clocks, radio, core, peripherals
// - eight 32-bit retention words survive hibernation
// - hibernation powers off slow and fast memory
// - system reset comes up fully active
// - wake enable is an eleven-bit source mask
// - each sleep mode honours its own source subset
// - single pad wake: selected pad, chosen level
// - multi pad high level: any pad wakes
// - multi pad low level: all pads low
// - deep sleep gpio wake uses low-power pads only
// - any sdio command wakes light sleep when enabled
// - serial wake after rising-edge count reaches threshold
// - wireless sources cycle keepalive, modem, light sleep
// - 48-bit timer counts slow clock ticks
// - only power-up reset clears the timer
// - timer alarm wake and periodic coprocessor triggers
// - select zero boots from slow memory vector
// - select one jumps only on crc match
// - deep sleep keeps both memories powered
// - register block has two base addresses
package swc_pkg;

  // power states; the numeric code is what o_power_mode shows
  typedef enum logic [2:0] {
    st_active,
    st_keep,
    st_modem,
    st_light,
    st_deep,
    st_hib
  } swc_state_type;

  typedef enum logic [1:0] {
    kind_light,
    kind_deep,
    kind_hib
  } swc_kind_type;

  localparam int SWC_SRC_N = 11;
  // wake source bit positions within the enable mask
  localparam int SWC_SRC_SINGLE = 0;
  localparam int SWC_SRC_MULTI  = 1;
  localparam int SWC_SRC_GPIO   = 2;
  localparam int SWC_SRC_TIMER  = 3;
  localparam int SWC_SRC_SDIO   = 4;
  localparam int SWC_SRC_WLAN   = 5;
  localparam int SWC_SRC_UART0  = 6;
  localparam int SWC_SRC_UART1  = 7;
  localparam int SWC_SRC_TOUCH  = 8;
  localparam int SWC_SRC_COP    = 9;
  localparam int SWC_SRC_RADIO  = 10;

  // sources honoured per mode
  localparam logic [10:0] SWC_MASK_LIGHT = 11'h7FF;
  localparam logic [10:0] SWC_MASK_DEEP  = 11'h30F;
  localparam logic [10:0] SWC_MASK_HIB   = 11'h00A;
  localparam logic [10:0] SWC_MASK_NONE  = 11'h000;

  localparam int SWC_PAD_N = 18;

  // power bits {osc8m, xtal, pll, radio, core, periph, slow_mem, fast_mem}
  localparam logic [7:0] SWC_PWR_ACTIVE = 8'hFF;
  localparam logic [7:0] SWC_PWR_MODEM  = 8'hEF;
  localparam logic [7:0] SWC_PWR_LIGHT  = 8'h0F;
  localparam logic [7:0] SWC_PWR_DEEP   = 8'h07;
  localparam logic [7:0] SWC_PWR_HIB    = 8'h00;

  // reset vectors
  localparam logic [31:0] SWC_VEC_SLOW_MEM = 32'h5000_0000;
  localparam logic [31:0] SWC_VEC_ROM      = 32'h4000_0400;

  // retention word indices holding crc and entry
  localparam logic [2:0] SWC_WORD_CRC   = 3'h6;
  localparam logic [2:0] SWC_WORD_ENTRY = 3'h7;

  // register block bases, kept for software headers
  localparam logic [31:0] SWC_BASE_AHB   = 32'h6000_8000;
  localparam logic [31:0] SWC_BASE_DUAL_PORT = 32'h3FF4_8000;

  function automatic logic [10:0] mode_mask(input swc_state_type st);
    case (st)
      st_light: mode_mask = SWC_MASK_LIGHT;
      st_deep:  mode_mask = SWC_MASK_DEEP;
      st_hib:   mode_mask = SWC_MASK_HIB;
      default:  mode_mask = SWC_MASK_NONE;
    endcase
  endfunction : mode_mask

  function automatic logic [7:0] mode_power(input swc_state_type st);
    case (st)
      st_modem: mode_power = SWC_PWR_MODEM;
      st_light: mode_power = SWC_PWR_LIGHT;
      st_deep:  mode_power = SWC_PWR_DEEP;
      st_hib:   mode_power = SWC_PWR_HIB;
      default:  mode_power = SWC_PWR_ACTIVE;
    endcase
  endfunction : mode_power

endpackage : swc_pkg

// ==== common/swc_ret_if.sv ====
// swc_ret_if: carrier between the controller and its retention word store
// assumes a single system clock shared by both ends
`timescale 1ns/1ps
interface swc_ret_if;
  logic        wr;
  logic [2:0]  waddr;
  logic [31:0] wdata;
  logic [2:0]  raddr;
  logic [31:0] rdata;
  logic [31:0] word_six;
  logic [31:0] word_seven;

  modport mem (input wr, input waddr, input wdata, input raddr,
               output rdata, output word_six, output word_seven);
  modport user (output wr, output waddr, output wdata, output raddr,
                input rdata, input word_six, input word_seven);
endinterface : swc_ret_if

// ==== design/swc_ret_mem.sv ====
// swc_ret_mem: eight always-on retention words with registered read
// assumes i_sys_rst is the power-up reset; sleep and soft resets never reach here
`timescale 1ns/1ps
module swc_ret_mem (
  input  wire logic i_clk_sys,
  input  wire logic i_sys_rst,
  swc_ret_if.mem    bus
);

  typedef struct packed {
    logic [7:0][31:0] words;
    logic [31:0]      rdata;
  } swc_mem_state_type;

  swc_mem_state_type s;
  swc_mem_state_type next_s;

  // read first, read port returns the word stored before any same-cycle write, one cycle later
  always_comb begin
    next_s = s;
    if (bus.wr) begin
      next_s.words[bus.waddr] = bus.wdata;
    end
    next_s.rdata = s.words[bus.raddr];
  end

  // only power-up clears the words, so content outlives every sleep mode
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.rdata      = s.rdata;
  assign bus.word_six   = s.words[swc_pkg::SWC_WORD_CRC];
  assign bus.word_seven = s.words[swc_pkg::SWC_WORD_ENTRY];

  word_six_store_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
    (bus.wr && bus.waddr == swc_pkg::SWC_WORD_CRC) |=> bus.word_six == $past(bus.wdata))
    else $error("retention word six did not take the write");

endmodule : swc_ret_mem

// ==== design/swc_top.sv ====
// swc_top: sleep mode sequencing, wake source qualification, low-power timer, boot vector
// assumes all inputs synchronous to i_clk_sys; i_slow_tick is one pulse per slow clock period
`timescale 1ns/1ps
module swc_top #(
  parameter int THR_W    = 10,
  parameter int PERIOD_W = 16
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_sys_rst,
  input  wire logic                  i_soft_rst,
  input  wire logic                  i_slow_tick,
  input  wire logic                  i_sleep_req,
  input  wire logic [1:0]            i_sleep_kind,
  input  wire logic [10:0]           i_wake_source_enable,
  input  wire logic [4:0]            i_single_pad_wake_select,
  input  wire logic                  i_single_pad_wake_level,
  input  wire logic [17:0]           i_multi_pad_wake_bitmap,
  input  wire logic                  i_multi_pad_wake_level,
  input  wire logic [17:0]           i_pads,
  input  wire logic                  i_gpio_lp_wake,
  input  wire logic                  i_gpio_dig_wake,
  input  wire logic                  i_sdio_cmd,
  input  wire logic [1:0]            i_uart_rx,
  input  wire logic [THR_W-1:0]      i_uart_threshold,
  input  wire logic                  i_touch_wake,
  input  wire logic                  i_cop_wake,
  input  wire logic                  i_wlan_wake,
  input  wire logic                  i_radio_wake,
  input  wire logic [PERIOD_W-1:0]   i_keepalive_period,
  input  wire logic                  i_link_done,
  input  wire logic                  i_alarm_enable,
  input  wire logic [47:0]           i_alarm_value,
  input  wire logic [PERIOD_W-1:0]   i_trigger_period,
  input  wire logic                  i_cause_clear,
  input  wire logic                  i_primary_cpu_boot_vector_select,
  input  wire logic                  i_second_cpu_boot_vector_select,
  input  wire logic                  i_crc_done,
  input  wire logic [31:0]           i_crc_value,
  input  wire logic                  i_ret_wr,
  input  wire logic [2:0]            i_ret_waddr,
  input  wire logic [31:0]           i_ret_wdata,
  input  wire logic [2:0]            i_ret_raddr,
  output logic      [31:0]           o_ret_rdata,
  output logic      [2:0]            o_power_mode,
  output logic                       o_osc8m_en,
  output logic                       o_xtal_en,
  output logic                       o_pll_en,
  output logic                       o_radio_en,
  output logic                       o_core_pwr,
  output logic                       o_periph_pwr,
  output logic                       o_slow_mem_pwr,
  output logic                       o_fast_mem_pwr,
  output logic                       o_cpu_stall,
  output logic                       o_wake_pulse,
  output logic      [10:0]           o_wake_cause,
  output logic      [47:0]           o_timer_value,
  output logic                       o_touch_trigger,
  output logic                       o_cop_trigger,
  output logic      [31:0]           o_primary_cpu_boot_vector,
  output logic      [31:0]           o_second_cpu_boot_vector,
  output logic                       o_fast_boot_jump,
  output logic      [31:0]           o_fast_boot_entry,
  output logic                       o_fast_boot_fail
);

  typedef struct packed {
    swc_pkg::swc_state_type     st;
    logic [7:0]                 pwr;
    logic                       stall;
    logic [47:0]                timer;
    logic [PERIOD_W-1:0]        trig_cnt;
    logic [PERIOD_W-1:0]        beacon_cnt;
    logic                       touch_trig;
    logic                       cop_trig;
    logic [1:0]                 rx_prev;
    logic [1:0][THR_W-1:0]      edge_cnt;
    logic [10:0]                cause;
    logic                       wake_pulse;
    logic [31:0]                pvec;
    logic [31:0]                svec;
    logic                       jump;
    logic                       crc_fail;
    logic [31:0]                entry;
  } swc_main_state_type;

  swc_main_state_type s;
  swc_main_state_type next_s;
  logic [10:0]        srcs;
  logic [10:0]        hits;
  logic               single_hit;
  logic               multi_hit;
  logic [17:0]        pads_sel;

  swc_ret_if ret ();

  swc_ret_mem u_ret_mem (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .bus       (ret.mem)
  );

  // retention port passes straight to the store; read data is its register
  assign ret.wr    = i_ret_wr;
  assign ret.waddr = i_ret_waddr;
  assign ret.wdata = i_ret_wdata;
  assign ret.raddr = i_ret_raddr;

  // pad level detection; a select beyond the last pad never fires
  always_comb begin
    pads_sel   = i_pads & i_multi_pad_wake_bitmap;
    single_hit = (int'(i_single_pad_wake_select) < swc_pkg::SWC_PAD_N) &&
                 (i_pads[i_single_pad_wake_select] == i_single_pad_wake_level);
    if (i_multi_pad_wake_level) begin
      multi_hit = |pads_sel;
    end else begin
      // empty bitmap would otherwise wake at once, so it counts as disarmed
      multi_hit = (|i_multi_pad_wake_bitmap) && !(|pads_sel);
    end
  end

  // raw source vector, one bit per enable position
  always_comb begin
    srcs = '0;
    srcs[swc_pkg::SWC_SRC_SINGLE] = single_hit;
    srcs[swc_pkg::SWC_SRC_MULTI]  = multi_hit;
    // digital gpio is unpowered in deep sleep, only the low-power pads count
    srcs[swc_pkg::SWC_SRC_GPIO]   = i_gpio_lp_wake ||
                                    (i_gpio_dig_wake && s.st != swc_pkg::st_deep);
    srcs[swc_pkg::SWC_SRC_TIMER]  = i_alarm_enable && (s.timer == i_alarm_value);
    srcs[swc_pkg::SWC_SRC_SDIO]   = i_sdio_cmd;
    srcs[swc_pkg::SWC_SRC_WLAN]   = i_wlan_wake;
    srcs[swc_pkg::SWC_SRC_UART0]  = (s.edge_cnt[0] >= i_uart_threshold);
    srcs[swc_pkg::SWC_SRC_UART1]  = (s.edge_cnt[1] >= i_uart_threshold);
    srcs[swc_pkg::SWC_SRC_TOUCH]  = i_touch_wake;
    srcs[swc_pkg::SWC_SRC_COP]    = i_cop_wake;
    srcs[swc_pkg::SWC_SRC_RADIO]  = i_radio_wake;
    hits = srcs & i_wake_source_enable & swc_pkg::mode_mask(s.st);
  end

  // next state of the whole controller
  always_comb begin
    next_s            = s;
    next_s.wake_pulse = 1'b0;
    next_s.touch_trig = 1'b0;
    next_s.cop_trig   = 1'b0;
    next_s.jump       = 1'b0;
    next_s.crc_fail   = 1'b0;
    next_s.rx_prev    = i_uart_rx;

    // free-running timer, untouched by the soft reset below
    if (i_slow_tick) begin
      next_s.timer = s.timer + 48'h1;
      if (s.trig_cnt == '0) begin
        next_s.touch_trig = 1'b1;
        next_s.cop_trig   = 1'b1;
        next_s.trig_cnt   = i_trigger_period;
      end else begin
        next_s.trig_cnt = s.trig_cnt - 1'b1;
      end
    end

    // rising edges on the direct pin mux receive lines, counted only in light sleep
    for (int u = 0; u < 2; u++) begin
      if (s.st != swc_pkg::st_light) begin
        next_s.edge_cnt[u] = '0;
      end else if (i_uart_rx[u] && !s.rx_prev[u] && s.edge_cnt[u] < i_uart_threshold) begin
        next_s.edge_cnt[u] = s.edge_cnt[u] + 1'b1;
      end
    end

    case (s.st)
      swc_pkg::st_active: begin
        if (i_sleep_req) begin
          if (i_sleep_kind == swc_pkg::kind_deep) begin
            next_s.st = swc_pkg::st_deep;
          end else if (i_sleep_kind == swc_pkg::kind_hib) begin
            next_s.st = swc_pkg::st_hib;
          end else begin
            next_s.st         = swc_pkg::st_light;
            next_s.beacon_cnt = i_keepalive_period;
          end
        end
      end
      swc_pkg::st_keep: begin
        // radio awake for the keepalive exchange, then drop to modem sleep
        if (i_link_done) begin
          next_s.st = swc_pkg::st_modem;
        end
      end
      swc_pkg::st_modem: begin
        if (i_slow_tick) begin
          next_s.st         = swc_pkg::st_light;
          next_s.beacon_cnt = i_keepalive_period;
        end
      end
      default: begin
        if (|hits) begin
          next_s.st         = swc_pkg::st_active;
          next_s.cause      = hits;
          next_s.wake_pulse = 1'b1;
        end else if (s.st == swc_pkg::st_light && i_slow_tick &&
                     (i_wake_source_enable[swc_pkg::SWC_SRC_WLAN] ||
                      i_wake_source_enable[swc_pkg::SWC_SRC_RADIO])) begin
          if (s.beacon_cnt == '0) begin
            next_s.st = swc_pkg::st_keep;
          end else begin
            next_s.beacon_cnt = s.beacon_cnt - 1'b1;
          end
        end
      end
    endcase

    // a new wake wins over a clear in the same cycle
    if (i_cause_clear && !next_s.wake_pulse) begin
      next_s.cause = '0;
    end

    // boot vectors follow the selects; zero picks slow memory and skips rom
    next_s.pvec = i_primary_cpu_boot_vector_select ? swc_pkg::SWC_VEC_ROM
                                                   : swc_pkg::SWC_VEC_SLOW_MEM;
    next_s.svec = i_second_cpu_boot_vector_select ? swc_pkg::SWC_VEC_ROM
                                                  : swc_pkg::SWC_VEC_SLOW_MEM;

    // rom recomputes the crc; jump only when it matches the stored word
    if (i_crc_done && i_primary_cpu_boot_vector_select) begin
      if (i_crc_value == ret.word_six) begin
        next_s.jump  = 1'b1;
        next_s.entry = ret.word_seven;
      end else begin
        next_s.crc_fail = 1'b1;
      end
    end

    // soft reset returns to active but leaves timer and retention alone
    if (i_soft_rst) begin
      next_s.st         = swc_pkg::st_active;
      next_s.cause      = '0;
      next_s.wake_pulse = 1'b0;
      next_s.jump       = 1'b0;
      next_s.crc_fail   = 1'b0;
    end

    // power controls follow the state they belong to, in the same cycle
    next_s.pwr   = swc_pkg::mode_power(next_s.st);
    next_s.stall = (next_s.st == swc_pkg::st_light);
  end

  // power-up reset: fully active, everything powered
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s     <= '0;
      s.st  <= swc_pkg::st_active;
      s.pwr <= swc_pkg::SWC_PWR_ACTIVE;
    end else begin
      s <= next_s;
    end
  end

  assign o_ret_rdata               = ret.rdata;
  assign o_power_mode              = s.st;
  assign {o_osc8m_en, o_xtal_en, o_pll_en, o_radio_en,
          o_core_pwr, o_periph_pwr, o_slow_mem_pwr, o_fast_mem_pwr} = s.pwr;
  assign o_cpu_stall               = s.stall;
  assign o_wake_pulse              = s.wake_pulse;
  assign o_wake_cause              = s.cause;
  assign o_timer_value             = s.timer;
  assign o_touch_trigger           = s.touch_trig;
  assign o_cop_trigger             = s.cop_trig;
  assign o_primary_cpu_boot_vector = s.pvec;
  assign o_second_cpu_boot_vector  = s.svec;
  assign o_fast_boot_jump          = s.jump;
  assign o_fast_boot_entry         = s.entry;
  assign o_fast_boot_fail          = s.crc_fail;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  soft_reset_active_a: assert property (
    i_soft_rst |=> o_power_mode == swc_pkg::st_active && o_core_pwr && o_radio_en)
    else $error("soft reset did not return to active");
  hib_power_off_a: assert property (
    s.st == swc_pkg::st_hib |-> !o_osc8m_en && !o_xtal_en && !o_pll_en && !o_radio_en &&
    !o_core_pwr && !o_periph_pwr)
    else $error("hibernation left a domain powered");
  hib_mem_off_a: assert property (
    s.st == swc_pkg::st_hib |-> !o_slow_mem_pwr && !o_fast_mem_pwr)
    else $error("hibernation kept memory powered");
  deep_mem_on_a: assert property (
    s.st == swc_pkg::st_deep |-> o_slow_mem_pwr && o_fast_mem_pwr && !o_core_pwr)
    else $error("deep sleep memory power wrong");
  hib_wake_mask_a: assert property (
    ($past(s.st) == swc_pkg::st_hib && o_wake_pulse) |->
    (o_wake_cause & ~swc_pkg::SWC_MASK_HIB) == 11'h000)
    else $error("hibernation woke on unsupported source");
  timer_tick_a: assert property (
    i_slow_tick |=> o_timer_value == $past(o_timer_value) + 48'h1)
    else $error("timer missed a slow tick");
  timer_hold_a: assert property (
    !i_slow_tick |=> $stable(o_timer_value))
    else $error("timer moved without a tick");
  single_pad_wake_a: assert property (
    (s.st == swc_pkg::st_light && !i_soft_rst &&
    i_wake_source_enable[swc_pkg::SWC_SRC_SINGLE] &&
    int'(i_single_pad_wake_select) < swc_pkg::SWC_PAD_N &&
    i_pads[i_single_pad_wake_select] == i_single_pad_wake_level) |=>
    o_wake_pulse && o_wake_cause[swc_pkg::SWC_SRC_SINGLE])
    else $error("single pad wake not taken");
  multi_pad_low_a: assert property (
    (s.st inside {swc_pkg::st_light, swc_pkg::st_deep, swc_pkg::st_hib} && !i_soft_rst &&
    i_wake_source_enable[swc_pkg::SWC_SRC_MULTI] && !i_multi_pad_wake_level &&
    i_multi_pad_wake_bitmap != 18'h00000 && (i_pads & i_multi_pad_wake_bitmap) == 18'h00000)
    |=> o_wake_cause[swc_pkg::SWC_SRC_MULTI])
    else $error("all-low multi pad wake not taken");
  slow_vector_a: assert property (
    !i_primary_cpu_boot_vector_select |=>
    o_primary_cpu_boot_vector == swc_pkg::SWC_VEC_SLOW_MEM)
    else $error("slow memory boot vector not selected");
  crc_jump_a: assert property (
    o_fast_boot_jump |-> $past(i_crc_value) == $past(ret.word_six) &&
    o_fast_boot_entry == $past(ret.word_seven))
    else $error("fast boot jumped without crc match");

endmodule : swc_top

// ==== verification/swc_wake_model.sv ====
// swc_wake_model: far side stand-in, slow clock ticks and two serial receive lines
// assumes the bench clock; ticks every TICK_DIV cycles, rx toggles while i_rx_run
`timescale 1ns/1ps
module swc_wake_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rx_run,
  output logic            o_slow_tick,
  output logic      [1:0] o_uart_rx
);
  int div = 0;
  initial begin
    o_slow_tick = 1'b0;
    o_uart_rx = 2'h0;
  end
  // free running, the slow clock keeps going through every reset
  always @(posedge i_clk_sys) begin
    div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    o_slow_tick <= #1 (div == TICK_DIV - 1);
    o_uart_rx <= #1 i_rx_run ? ~o_uart_rx : 2'h0;  // one rising edge per two cycles
  end
endmodule : swc_wake_model

// ==== verification/testbench.sv ====
// testbench: directed scenarios for swc_top, one task each
// assumes swc_wake_model supplies slow ticks and serial receive edges
`timescale 1ns/1ps
module testbench;
  logic i_clk_sys, i_sys_rst, i_soft_rst, i_slow_tick, i_sleep_req, i_single_pad_wake_level;
  logic i_multi_pad_wake_level, i_gpio_lp_wake, i_gpio_dig_wake, i_sdio_cmd, i_touch_wake;
  logic i_cop_wake, i_alarm_enable, i_cause_clear, i_crc_done, i_ret_wr, rx_run;
  logic i_primary_cpu_boot_vector_select, i_second_cpu_boot_vector_select;
  logic [1:0] i_sleep_kind, i_uart_rx;
  logic [2:0] i_ret_waddr, i_ret_raddr, o_power_mode;
  logic [4:0] i_single_pad_wake_select;
  logic [9:0] i_uart_threshold;
  logic [10:0] i_wake_source_enable, o_wake_cause;
  logic [17:0] i_multi_pad_wake_bitmap, i_pads;
  logic [31:0] i_crc_value, i_ret_wdata, o_ret_rdata, o_primary_cpu_boot_vector, o_fast_boot_entry;
  logic [47:0] i_alarm_value, o_timer_value, t0;
  logic o_osc8m_en, o_xtal_en, o_pll_en, o_radio_en, o_core_pwr, o_periph_pwr, o_slow_mem_pwr;
  logic o_fast_mem_pwr, o_cpu_stall, o_wake_pulse, o_fast_boot_jump, o_fast_boot_fail;
  logic o_touch_trigger, o_cop_trigger, link_done;
  logic [31:0] o_second_cpu_boot_vector;
  int failures = 0, num_checks = 0, cycles = 0;
  wire [7:0] pwr = {o_osc8m_en, o_xtal_en, o_pll_en, o_radio_en, o_core_pwr, o_periph_pwr,
                    o_slow_mem_pwr, o_fast_mem_pwr};
  // wireless wake inputs stay low; keepalive needs only the enable bit
  swc_top dut_u (.i_clk_sys, .i_sys_rst, .i_soft_rst, .i_slow_tick, .i_sleep_req, .i_sleep_kind,
    .i_wake_source_enable, .i_single_pad_wake_select, .i_single_pad_wake_level,
    .i_multi_pad_wake_bitmap, .i_multi_pad_wake_level, .i_pads, .i_gpio_lp_wake,
    .i_gpio_dig_wake, .i_sdio_cmd, .i_uart_rx, .i_uart_threshold, .i_touch_wake, .i_cop_wake,
    .i_wlan_wake(1'b0), .i_radio_wake(1'b0), .i_keepalive_period(16'h0010),
    .i_link_done(link_done),
    .i_alarm_enable, .i_alarm_value, .i_trigger_period(16'h0007), .i_cause_clear,
    .i_primary_cpu_boot_vector_select, .i_second_cpu_boot_vector_select, .i_crc_done,
    .i_crc_value, .i_ret_wr, .i_ret_waddr, .i_ret_wdata, .i_ret_raddr, .o_ret_rdata,
    .o_power_mode, .o_osc8m_en, .o_xtal_en, .o_pll_en, .o_radio_en, .o_core_pwr, .o_periph_pwr,
    .o_slow_mem_pwr, .o_fast_mem_pwr, .o_cpu_stall, .o_wake_pulse, .o_wake_cause,
    .o_timer_value, .o_touch_trigger, .o_cop_trigger, .o_primary_cpu_boot_vector,
    .o_second_cpu_boot_vector, .o_fast_boot_jump, .o_fast_boot_entry, .o_fast_boot_fail);
  swc_wake_model wm_u (.i_clk_sys, .i_rx_run(rx_run), .o_slow_tick(i_slow_tick),
    .o_uart_rx(i_uart_rx));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // bounded run, a hang ends in the closing report
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic enter(input logic [1:0] kind, input logic [2:0] mode, input logic [7:0] pw);
    i_sleep_kind = kind;
    i_sleep_req = 1'b1;
    cyc(1);
    i_sleep_req = 1'b0;
    chk("mode", mode, o_power_mode);
    chk("power", pw, pwr);
  endtask : enter
  // wait is bounded; a missing wake shows up as a pulse mismatch
  task automatic woke(input logic [10:0] cause);
    for (int k = 0; k < 40 && o_wake_pulse !== 1'b1; k++) cyc(1);
    chk("pulse", 1'b1, o_wake_pulse);
    chk("cause", cause, o_wake_cause);
    chk("mode", 3'h0, o_power_mode);
  endtask : woke
  task automatic s_single;
    i_wake_source_enable = 11'h003;
    i_multi_pad_wake_level = 1'b1;
    enter(2'h0, 3'h3, 8'h0F);
    chk("stall", 1'b1, o_cpu_stall);
    i_pads = 18'h00010;
    cyc(3);
    chk("mode", 3'h3, o_power_mode);
    i_pads = 18'h00020;
    woke(11'h001);
    i_pads = 18'h0;
    enter(2'h0, 3'h3, 8'h0F);
    i_pads = 18'h00200;
    woke(11'h002);
    i_pads = 18'h0;
    i_multi_pad_wake_level = 1'b0;
  endtask : s_single
  task automatic s_deep;
    i_wake_source_enable = 11'h7FD;
    enter(2'h1, 3'h4, 8'h07);
    i_gpio_dig_wake = 1'b1;
    i_sdio_cmd = 1'b1;
    cyc(4);
    chk("mode", 3'h4, o_power_mode);
    i_gpio_dig_wake = 1'b0;
    i_gpio_lp_wake = 1'b1;
    woke(11'h004);
    i_gpio_lp_wake = 1'b0;
    enter(2'h0, 3'h3, 8'h0F);
    woke(11'h010);
    i_sdio_cmd = 1'b0;
  endtask : s_deep
  task automatic s_hib;
    i_ret_wr = 1'b1;
    i_ret_waddr = 3'h6;
    i_ret_wdata = 32'h1234ABCD;
    cyc(1);
    i_ret_waddr = 3'h7;
    i_ret_wdata = 32'h00001000;
    cyc(1);
    i_ret_wr = 1'b0;
    i_wake_source_enable = 11'h003;
    i_single_pad_wake_level = 1'b0;
    i_pads = 18'h00100;
    enter(2'h2, 3'h5, 8'h00);
    cyc(3);
    chk("mode", 3'h5, o_power_mode);
    i_pads = 18'h0;
    woke(11'h002);
    i_single_pad_wake_level = 1'b1;
    i_ret_raddr = 3'h6;
    cyc(2);
    chk("word", 32'h1234ABCD, o_ret_rdata);
  endtask : s_hib
  task automatic s_boot;
    chk("vector", 32'h50000000, o_primary_cpu_boot_vector);
    i_primary_cpu_boot_vector_select = 1'b1;
    cyc(2);
    chk("vector", 32'h40000400, o_primary_cpu_boot_vector);
    chk("vector2", 32'h50000000, o_second_cpu_boot_vector);
    i_crc_done = 1'b1;
    i_crc_value = 32'h1234ABCD;
    cyc(1);
    chk("jump", 1'b1, o_fast_boot_jump);
    chk("entry", 32'h00001000, o_fast_boot_entry);
    i_crc_value = 32'h1234ABCE;
    cyc(1);
    i_crc_done = 1'b0;
    chk("fail", 1'b1, o_fast_boot_fail);
    chk("jump", 1'b0, o_fast_boot_jump);
  endtask : s_boot
  task automatic s_timer;
    t0 = o_timer_value;
    cyc(16);
    chk("timer", t0 + 48'h4, o_timer_value);
    enter(2'h0, 3'h3, 8'h0F);
    i_soft_rst = 1'b1;
    cyc(1);
    i_soft_rst = 1'b0;
    chk("mode", 3'h0, o_power_mode);
    cyc(14);
    chk("timer", t0 + 48'h8, o_timer_value);
    i_wake_source_enable = 11'h008;
    enter(2'h1, 3'h4, 8'h07);
    i_alarm_value = o_timer_value + 48'h2;
    i_alarm_enable = 1'b1;
    woke(11'h008);
    i_alarm_enable = 1'b0;
  endtask : s_timer
  task automatic s_uart;
    i_wake_source_enable = 11'h040;
    enter(2'h0, 3'h3, 8'h0F);
    rx_run = 1'b1;
    woke(11'h040);
    rx_run = 1'b0;
    i_cause_clear = 1'b1;
    cyc(1);
    i_cause_clear = 1'b0;
    chk("cause", 11'h000, o_wake_cause);
  endtask : s_uart
  task automatic s_keep;
    i_wake_source_enable = 11'h020;
    enter(2'h0, 3'h3, 8'h0F);
    for (int k = 0; k < 80 && o_power_mode !== 3'h1; k++) cyc(1);
    chk("mode", 3'h1, o_power_mode);
    chk("power", 8'hFF, pwr);
    link_done = 1'b1;
    cyc(1);
    link_done = 1'b0;
    chk("power", 8'hEF, pwr);
    for (int k = 0; k < 8 && o_power_mode !== 3'h3; k++) cyc(1);
    chk("mode", 3'h3, o_power_mode);
    i_soft_rst = 1'b1;
    cyc(1);
    i_soft_rst = 1'b0;
  endtask : s_keep
  task automatic s_trig;
    int n;
    for (n = 0; n < 40 && o_touch_trigger !== 1'b1; n++) cyc(1);
    chk("cop", 1'b1, o_cop_trigger);
    cyc(1);
    for (n = 1; n < 40 && o_touch_trigger !== 1'b1; n++) cyc(1);
    chk("period", 48'h20, n);
  endtask : s_trig
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // every input given a value before reset releases
  initial begin
    {i_soft_rst, i_sleep_req, i_gpio_lp_wake, i_gpio_dig_wake, i_sdio_cmd, i_touch_wake} = '0;
    {i_cop_wake, i_alarm_enable, i_cause_clear, i_crc_done, i_ret_wr, rx_run, link_done} = '0;
    {i_primary_cpu_boot_vector_select, i_second_cpu_boot_vector_select} = 2'h0;
    {i_sleep_kind, i_ret_waddr, i_ret_raddr, i_ret_wdata, i_crc_value, i_alarm_value} = '0;
    {i_wake_source_enable, i_multi_pad_wake_level, i_pads} = '0;
    i_single_pad_wake_select = 5'h05;
    i_single_pad_wake_level = 1'b1;
    i_multi_pad_wake_bitmap = 18'h00300;
    i_uart_threshold = 10'h003;
    i_sys_rst = 1'b1;
    cyc(3);
    i_sys_rst = 1'b0;
    cyc(1);
    chk("mode", 3'h0, o_power_mode);
    chk("power", 8'hFF, pwr);
    s_single();
    s_deep();
    s_hib();
    s_boot();
    s_timer();
    s_uart();
    s_keep();
    s_trig();
    report_and_stop();
  end
endmodule : testbench
